// file: hw/event_status_bank.sv
// Sticky event status, enable mask and level interrupt
`timescale 1ns/1ps
module event_status_bank #(
    parameter int W = 5
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] set_i,
    input wire logic clr_wr_i,
    input wire logic en_wr_i,
    input wire logic [W-1:0] wdata_i,
    output logic [W-1:0] status_o,
    output logic [W-1:0] enable_o,
    output logic irq_o
);

    typedef struct packed {
        logic [W-1:0] status;
        logic [W-1:0] enable;
        logic irq;
    } bank_t;

    bank_t state;
    bank_t next_state;

    // A set in the clearing cycle wins so no event is lost
    always_comb begin
        next_state = state;
        if (clr_wr_i) begin
            next_state.status = state.status & ~wdata_i;
        end
        next_state.status = next_state.status | set_i;
        if (en_wr_i) begin
            next_state.enable = wdata_i;
        end
        next_state.irq = |(next_state.status & next_state.enable);
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign status_o = state.status;
    assign enable_o = state.enable;
    assign irq_o = state.irq;

endmodule : event_status_bank

// file: hw/port_pin_logic.sv
// Pin logic for the eight-line bidirectional port and the fixed port
//
// Operation
// - Each of eight bidirectional lines is set input or output alone.
// - All output lines share one drive style: push-pull or open-drain.
// - After reset every bidirectional line is an input.
// - The bidirectional port always serves plain input and output.
// - Eight-input OR and AND of the port inputs can wake the part.
// - Line zero may feed the timer edge detector in demodulation mode.
// - Fixed inputs one, two, three raise requests c, a, b.
// - Fixed lines 0-3 are inputs; 4-7 carry timer and comparator outputs.
// - Timer and AND/OR outputs reach pins only as timer controls select.
// - Both comparators are powered down in the stop state.
// - Config bit zero routes comparator outputs to lines four and seven.
`timescale 1ns/1ps
module port_pin_logic #(
    parameter int BIDIR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Bidirectional port pins
    input wire logic [BIDIR_W-1:0] bidir_port_lines_i,
    output logic [BIDIR_W-1:0] bidir_port_lines_o,
    output logic [BIDIR_W-1:0] bidir_port_lines_oe_b_o,
    // Fixed port pins
    input wire logic analog_ref_in0_i,
    input wire logic fixed_in1_i,
    input wire logic fixed_in2_i,
    input wire logic fixed_in3_i,
    output logic fixed_out4_o,
    output logic fixed_out5_o,
    output logic fixed_out6_o,
    output logic fixed_out7_o,
    // Core-side signals
    input wire logic byte_timer_out_i,
    input wire logic word_timer_out_i,
    input wire logic combined_timer_out_i,
    input wire logic comparator_a_out_i,
    input wire logic comparator_b_out_i,
    input wire logic stop_i,
    output logic edge_detect_in_o,
    output logic comparator_power_down_o,
    output logic ext_int_req_a_o,
    output logic ext_int_req_b_o,
    output logic ext_int_req_c_o,
    output logic wake_or_o,
    output logic wake_and_o,
    output logic stop_recovery_digital_o,
    output logic irq_o
);

    // ************************************************************
    // Elaboration check
    // ************************************************************
    // The wake gates and the byte-wide registers assume eight lines
    generate
        if (BIDIR_W != 8) begin : g_bad_width
            $error("port_pin_logic serves exactly eight lines");
        end
    endgenerate

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0] out_latch;
        logic [7:0] dir;
        logic [1:0] port_cfg;
        logic [7:0] timer_ctl0;
        logic [7:0] timer_ctl1;
        logic [7:0] timer_ctl2;
        logic [3:0] fixed_latch;
        logic [1:0] misc;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] bidir_o;
        logic [7:0] bidir_oe_b;
        logic [3:0] fixed_out;
        logic [2:0] fixed_prev;
        logic [2:0] int_req;
        logic edge_in;
        logic comp_pd;
        logic wake_or;
        logic wake_and;
    } port_state_t;

    port_state_t state;
    port_state_t next_state;

    logic [port_pins_pkg::INT_W-1:0] ev_set;
    logic [port_pins_pkg::INT_W-1:0] int_status;
    logic [port_pins_pkg::INT_W-1:0] int_enable;
    logic clr_wr;
    logic en_wr;
    logic bank_irq;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Mixed read view: pin level for inputs, latch for outputs
    function automatic logic [7:0] port_view(input logic [7:0] pins,
                                             input logic [7:0] latch,
                                             input logic [7:0] dir);
        port_view = (pins & ~dir) | (latch & dir);
    endfunction : port_view

    function automatic logic [31:0] zext8(input logic [7:0] v);
        zext8 = {24'h000000, v};
    endfunction : zext8

    // Access phase write strobe, usable for any offset
    function automatic logic wr_hit(input logic sel, input logic en,
                                    input logic wr, input logic rdy,
                                    input logic [7:0] addr,
                                    input logic [7:0] ofs);
        wr_hit = sel & en & wr & rdy & (addr == ofs);
    endfunction : wr_hit

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        logic [7:0] rd;
        logic mapped;
        logic or_term;
        logic and_term;
        logic [2:0] fixed_now;
        logic [1:0] sel6;
        logic [7:0] view;
        rd = 8'h00;
        mapped = 1'b1;
        or_term = 1'b0;
        and_term = 1'b1;
        sel6 = 2'b00;
        view = port_view(bidir_port_lines_i, state.out_latch, state.dir);
        fixed_now = {fixed_in3_i, fixed_in2_i, fixed_in1_i};
        next_state = state;

        // Output lines force the gate's neutral value so only inputs count
        or_term = |(bidir_port_lines_i & ~state.dir);
        and_term = &(bidir_port_lines_i | state.dir);
        next_state.wake_or = or_term;
        next_state.wake_and = and_term;

        // Read data is prepared in setup so the access phase has no wait
        unique case (paddr_i)
            port_pins_pkg::OFS_BIDIR_OUT: rd = state.out_latch;
            port_pins_pkg::OFS_BIDIR_DIR: rd = state.dir;
            port_pins_pkg::OFS_BIDIR_IN: rd = view;
            port_pins_pkg::OFS_PORT_CFG: rd = {6'h00, state.port_cfg};
            port_pins_pkg::OFS_TIMER_CTL0: rd = state.timer_ctl0;
            port_pins_pkg::OFS_TIMER_CTL1: rd = state.timer_ctl1;
            port_pins_pkg::OFS_TIMER_CTL2: rd = state.timer_ctl2;
            port_pins_pkg::OFS_FIXED_OUT: rd = {state.fixed_latch, 4'h0};
            port_pins_pkg::OFS_FIXED_IN:
                rd = {1'b0, state.wake_and, state.wake_or, stop_i,
                      fixed_now, analog_ref_in0_i};
            port_pins_pkg::OFS_MISC: rd = {6'h00, state.misc};
            port_pins_pkg::OFS_INT_STATUS: rd = {3'h0, int_status};
            port_pins_pkg::OFS_INT_CLEAR: rd = 8'h00;
            port_pins_pkg::OFS_INT_ENABLE: rd = {3'h0, int_enable};
            default: mapped = 1'b0;
        endcase

        // APB: setup cycle loads answer, access cycle completes it
        next_state.pready = psel_i & ~penable_i;
        next_state.pslverr = psel_i & ~penable_i & ~mapped;
        if (psel_i && !penable_i) begin
            next_state.prdata = (mapped && !pwrite_i) ? zext8(rd) : 32'h0;
        end

        // Register writes take effect on the completing edge only
        if (wr_hit(psel_i, penable_i, pwrite_i, state.pready, paddr_i,
                   port_pins_pkg::OFS_BIDIR_OUT)) begin
            next_state.out_latch = pwdata_i[7:0];
        end
        if (wr_hit(psel_i, penable_i, pwrite_i, state.pready, paddr_i,
                   port_pins_pkg::OFS_BIDIR_DIR)) begin
            next_state.dir = pwdata_i[7:0];
        end
        if (wr_hit(psel_i, penable_i, pwrite_i, state.pready, paddr_i,
                   port_pins_pkg::OFS_PORT_CFG)) begin
            next_state.port_cfg = pwdata_i[1:0];
        end
        if (wr_hit(psel_i, penable_i, pwrite_i, state.pready, paddr_i,
                   port_pins_pkg::OFS_TIMER_CTL0)) begin
            next_state.timer_ctl0 = pwdata_i[7:0];
        end
        if (wr_hit(psel_i, penable_i, pwrite_i, state.pready, paddr_i,
                   port_pins_pkg::OFS_TIMER_CTL1)) begin
            next_state.timer_ctl1 = pwdata_i[7:0];
        end
        if (wr_hit(psel_i, penable_i, pwrite_i, state.pready, paddr_i,
                   port_pins_pkg::OFS_TIMER_CTL2)) begin
            next_state.timer_ctl2 = pwdata_i[7:0];
        end
        if (wr_hit(psel_i, penable_i, pwrite_i, state.pready, paddr_i,
                   port_pins_pkg::OFS_FIXED_OUT)) begin
            next_state.fixed_latch = pwdata_i[7:4];
        end
        if (wr_hit(psel_i, penable_i, pwrite_i, state.pready, paddr_i,
                   port_pins_pkg::OFS_MISC)) begin
            next_state.misc = pwdata_i[1:0];
        end

        // Bidirectional drivers; never taken over by another function
        if (state.port_cfg[port_pins_pkg::CFG_PUSH_PULL]) begin
            next_state.bidir_o = state.out_latch;
            next_state.bidir_oe_b = ~state.dir;
        end else begin
            // Open-drain only pulls low; a high latch releases the line
            next_state.bidir_o = 8'h00;
            next_state.bidir_oe_b = ~(state.dir & ~state.out_latch);
        end

        // Demodulation input source for the edge detector
        next_state.edge_in = state.misc[port_pins_pkg::MISC_DEMOD_SEL]
            ? view[0]
            : fixed_in1_i;

        // Requests fire on a falling edge of the fixed inputs
        next_state.fixed_prev = fixed_now;
        next_state.int_req[0] = state.fixed_prev[1] & ~fixed_in2_i;
        next_state.int_req[1] = state.fixed_prev[2] & ~fixed_in3_i;
        next_state.int_req[2] = state.fixed_prev[0] & ~fixed_in1_i;

        // Comparators are held off for the stop state, registered one cycle late
        next_state.comp_pd = stop_i;

        // Line four: comparator a beats byte timer beats latch
        if (state.port_cfg[port_pins_pkg::CFG_COMP_ROUTE]) begin
            next_state.fixed_out[0] = comparator_a_out_i;
        end else if (state.timer_ctl0[port_pins_pkg::CTL_OUT_EN]) begin
            next_state.fixed_out[0] = byte_timer_out_i;
        end else begin
            next_state.fixed_out[0] = state.fixed_latch[0];
        end

        // Line five: word timer
        next_state.fixed_out[1] =
            state.timer_ctl2[port_pins_pkg::CTL_OUT_EN]
            ? word_timer_out_i : state.fixed_latch[1];

        // Line six: combined timer or the wake gates, by a two-bit field
        sel6 = state.timer_ctl1[port_pins_pkg::CTL1_SEL_HI:
                                port_pins_pkg::CTL1_SEL_LO];
        unique case (port_pins_pkg::sel6_t'(sel6))
            port_pins_pkg::SEL6_LATCH:
                next_state.fixed_out[2] = state.fixed_latch[2];
            port_pins_pkg::SEL6_TIMER:
                next_state.fixed_out[2] = combined_timer_out_i;
            port_pins_pkg::SEL6_OR:
                next_state.fixed_out[2] = state.wake_or;
            port_pins_pkg::SEL6_AND:
                next_state.fixed_out[2] = state.wake_and;
        endcase

        // Line seven: comparator b when routed, else latch
        next_state.fixed_out[3] =
            state.port_cfg[port_pins_pkg::CFG_COMP_ROUTE]
            ? comparator_b_out_i : state.fixed_latch[3];
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= '0;
            state.out_latch <= port_pins_pkg::RST_BIDIR_OUT;
            state.dir <= port_pins_pkg::RST_BIDIR_DIR;
            state.port_cfg <= port_pins_pkg::RST_PORT_CFG;
            state.timer_ctl0 <= port_pins_pkg::RST_TIMER_CTL;
            state.timer_ctl1 <= port_pins_pkg::RST_TIMER_CTL;
            state.timer_ctl2 <= port_pins_pkg::RST_TIMER_CTL;
            state.fixed_latch <= port_pins_pkg::RST_FIXED_OUT;
            state.misc <= port_pins_pkg::RST_MISC;
            state.bidir_oe_b <= 8'hff;
            state.fixed_prev <= 3'h7; // Idle high: a line low as reset ends raises its request
            state.wake_and <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Interrupt status bank
    // ************************************************************
    assign ev_set = {state.wake_and & ~next_state.wake_and,
                     ~state.wake_or & next_state.wake_or,
                     state.int_req};
    assign clr_wr = wr_hit(psel_i, penable_i, pwrite_i, state.pready,
                           paddr_i, port_pins_pkg::OFS_INT_CLEAR);
    assign en_wr = wr_hit(psel_i, penable_i, pwrite_i, state.pready,
                          paddr_i, port_pins_pkg::OFS_INT_ENABLE);

    event_status_bank #(
        .W(port_pins_pkg::INT_W)
    ) u_events (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .set_i(ev_set),
        .clr_wr_i(clr_wr),
        .en_wr_i(en_wr),
        .wdata_i(pwdata_i[port_pins_pkg::INT_W-1:0]),
        .status_o(int_status),
        .enable_o(int_enable),
        .irq_o(bank_irq)
    );

    // ************************************************************
    // Outputs, all from flip-flops
    // ************************************************************
    assign prdata_o = state.prdata;
    assign pready_o = state.pready;
    assign pslverr_o = state.pslverr;
    assign bidir_port_lines_o = state.bidir_o;
    assign bidir_port_lines_oe_b_o = state.bidir_oe_b;
    assign fixed_out4_o = state.fixed_out[0];
    assign fixed_out5_o = state.fixed_out[1];
    assign fixed_out6_o = state.fixed_out[2];
    assign fixed_out7_o = state.fixed_out[3];
    assign edge_detect_in_o = state.edge_in;
    assign comparator_power_down_o = state.comp_pd;
    assign ext_int_req_a_o = state.int_req[0];
    assign ext_int_req_b_o = state.int_req[1];
    assign ext_int_req_c_o = state.int_req[2];
    assign wake_or_o = state.wake_or;
    assign wake_and_o = state.wake_and;
    // Stop recovery may use fixed inputs only once software set digital
    assign stop_recovery_digital_o =
        state.misc[port_pins_pkg::MISC_DIGITAL];
    assign irq_o = bank_irq;

endmodule : port_pin_logic

// file: hw/port_pins_pkg.sv
// Constants shared by the two-port pin logic and its status bank
package port_pins_pkg;

    // ************************************************************
    // Register byte offsets on the APB bus
    // ************************************************************
    localparam logic [7:0] OFS_BIDIR_OUT = 8'h00;
    localparam logic [7:0] OFS_BIDIR_DIR = 8'h04;
    localparam logic [7:0] OFS_BIDIR_IN = 8'h08;
    localparam logic [7:0] OFS_PORT_CFG = 8'h0c;
    localparam logic [7:0] OFS_TIMER_CTL0 = 8'h10;
    localparam logic [7:0] OFS_TIMER_CTL1 = 8'h14;
    localparam logic [7:0] OFS_TIMER_CTL2 = 8'h18;
    localparam logic [7:0] OFS_FIXED_OUT = 8'h1c;
    localparam logic [7:0] OFS_FIXED_IN = 8'h20;
    localparam logic [7:0] OFS_MISC = 8'h24;
    localparam logic [7:0] OFS_INT_STATUS = 8'h28;
    localparam logic [7:0] OFS_INT_CLEAR = 8'h2c;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h30;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CFG_COMP_ROUTE = 0;
    localparam int CFG_PUSH_PULL = 1;
    localparam int CTL_OUT_EN = 0;
    localparam int CTL1_SEL_LO = 4;
    localparam int CTL1_SEL_HI = 5;
    localparam int MISC_DEMOD_SEL = 0;
    localparam int MISC_DIGITAL = 1;
    localparam int FIN_STOP = 4;
    localparam int FIN_WAKE_OR = 5;
    localparam int FIN_WAKE_AND = 6;

    // Interrupt status bits
    localparam int INT_W = 5;
    localparam int EV_REQ_A = 0;
    localparam int EV_REQ_B = 1;
    localparam int EV_REQ_C = 2;
    localparam int EV_WAKE_OR = 3;
    localparam int EV_WAKE_AND = 4;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_BIDIR_OUT = 8'h00;
    localparam logic [7:0] RST_BIDIR_DIR = 8'h00;
    localparam logic [1:0] RST_PORT_CFG = 2'h0;
    localparam logic [7:0] RST_TIMER_CTL = 8'h00;
    localparam logic [3:0] RST_FIXED_OUT = 4'h0;
    localparam logic [1:0] RST_MISC = 2'h0;

    // Selection for the combined-timer line
    typedef enum logic [1:0] {
        SEL6_LATCH = 2'b00,
        SEL6_TIMER = 2'b01,
        SEL6_OR = 2'b10,
        SEL6_AND = 2'b11
    } sel6_t;

endpackage : port_pins_pkg

// file: tb/bidir_pin_model.sv
// Far-side pin model for the bidirectional lines
`timescale 1ns/1ps
module bidir_pin_model #(
    parameter int W = 8
) (
    input wire logic [W-1:0] dut_out_i,
    input wire logic [W-1:0] dut_oe_b_i,
    input wire logic ext_en_i,
    input wire logic [W-1:0] ext_val_i,
    output logic [W-1:0] wire_o
);
    // Device wins where its enable is low; a released line with no outside
    // driver floats up on its pull-up, so a stale value can never be read
    assign wire_o = (~dut_oe_b_i & dut_out_i) |
        (dut_oe_b_i & (ext_en_i ? ext_val_i : {W{1'b1}}));
endmodule : bidir_pin_model

// file: tb/port2_port3_pin_logic_tb.sv
// Self-checking bench for the two-port pin logic
`timescale 1ns/1ps
module port2_port3_pin_logic_tb;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, edge_o, pdn_o, wk_or, wk_and, dig, irq;
    logic [7:0] bidir_o, oe_b, lines;
    logic [7:0] ext_val = 8'h00;
    logic ext_en = 1'b0;
    logic [3:0] fin = 4'hf;
    logic [4:0] tmr = 5'h00;
    logic stop = 1'b0;
    logic [3:0] fo;
    int miscompares = 0, total_checks = 0, cycles = 0;

    port_pin_logic #(.BIDIR_W(8)) u_dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .bidir_port_lines_i(lines),
        .bidir_port_lines_o(bidir_o), .bidir_port_lines_oe_b_o(oe_b),
        .analog_ref_in0_i(fin[0]), .fixed_in1_i(fin[1]),
        .fixed_in2_i(fin[2]), .fixed_in3_i(fin[3]),
        .fixed_out4_o(fo[0]), .fixed_out5_o(fo[1]), .fixed_out6_o(fo[2]),
        .fixed_out7_o(fo[3]), .byte_timer_out_i(tmr[0]),
        .word_timer_out_i(tmr[1]), .combined_timer_out_i(tmr[2]),
        .comparator_a_out_i(tmr[3]), .comparator_b_out_i(tmr[4]),
        .stop_i(stop), .edge_detect_in_o(edge_o),
        .comparator_power_down_o(pdn_o), .ext_int_req_a_o(),
        .ext_int_req_b_o(), .ext_int_req_c_o(), .wake_or_o(wk_or),
        .wake_and_o(wk_and), .stop_recovery_digital_o(dig), .irq_o(irq));

    bidir_pin_model #(.W(8)) u_pins (
        .dut_out_i(bidir_o), .dut_oe_b_i(oe_b), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .wire_o(lines));

    // ****************************************
    // Clock, timeout and verdict
    // ****************************************
    initial forever #2 clk_i = ~clk_i;

    // Whole run is under two hundred cycles; the ceiling only catches a hang
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude();
        if (miscompares == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    // ****************************************
    // Access tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Request held until the edge that samples ready high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        // Ready is looked at settled; it stands until the completing edge
        @(negedge clk_i);
        while (pready_o !== 1'b1) begin
            @(negedge clk_i);
        end
        q = prdata_o;
        e = pslverr_o;
        @(posedge clk_i);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic wt();
        repeat (3) @(posedge clk_i);
    endtask : wt

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
        wt();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic ex);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x);
        chk({31'h0, e}, {31'h0, ex});
    endtask : rd

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        logic [4:0] ev;
        ev = 5'h00;
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        chk(oe_b, 8'hff);
        rd(port_pins_pkg::OFS_BIDIR_DIR, 32'h0, 1'b0);
        rd(8'h3c, 32'h0, 1'b1);
        // Staggered falls tell the three request lines apart
        wr(port_pins_pkg::OFS_INT_CLEAR, 32'h1f);
        for (int i = 1; i < 4; i++) begin
            fin[i] <= 1'b0;
            ev[(i + 1) % 3] = 1'b1;
            wt();
            rd(port_pins_pkg::OFS_INT_STATUS, {27'h0, ev}, 1'b0);
        end
        chk(irq, 1'b0);
        wr(port_pins_pkg::OFS_INT_ENABLE, 32'h04);
        chk(irq, 1'b1);
        wr(port_pins_pkg::OFS_INT_CLEAR, 32'h07);
        chk(irq, 1'b0);
        fin <= 4'hf;
        // Push-pull then open-drain on a mixed direction pattern
        wr(port_pins_pkg::OFS_PORT_CFG, 32'h02);
        wr(port_pins_pkg::OFS_BIDIR_OUT, 32'ha5);
        wr(port_pins_pkg::OFS_BIDIR_DIR, 32'h0f);
        ext_en <= 1'b1;
        ext_val <= 8'h3c;
        wt();
        chk(oe_b, 8'hf0);
        chk(bidir_o, 8'ha5);
        rd(port_pins_pkg::OFS_BIDIR_IN, 32'h35, 1'b0);
        chk({wk_or, wk_and}, 2'b10);
        ext_val <= 8'hf0;
        wt();
        chk(wk_and, 1'b1);
        ext_val <= 8'h00;
        wt();
        chk(wk_or, 1'b0);
        wr(port_pins_pkg::OFS_PORT_CFG, 32'h00);
        chk({oe_b, bidir_o}, 16'hf500);
        rd(port_pins_pkg::OFS_BIDIR_IN, 32'h05, 1'b0);
        // Line zero to the edge detector, port still readable
        wr(port_pins_pkg::OFS_BIDIR_DIR, 32'h00);
        wr(port_pins_pkg::OFS_MISC, 32'h01);
        ext_val <= 8'h01;
        wt();
        chk(edge_o, 1'b1);
        rd(port_pins_pkg::OFS_BIDIR_IN, 32'h01, 1'b0);
        ext_val <= 8'h00;
        wt();
        chk(edge_o, 1'b0);
        // Fixed outputs: latch, timers, comparators, AND/OR logic
        wr(port_pins_pkg::OFS_FIXED_OUT, 32'hf0);
        chk(fo, 4'hf);
        wr(port_pins_pkg::OFS_TIMER_CTL0, 32'h01);
        wr(port_pins_pkg::OFS_TIMER_CTL2, 32'h01);
        wr(port_pins_pkg::OFS_TIMER_CTL1, 32'h10);
        chk(fo, 4'h8);
        wr(port_pins_pkg::OFS_PORT_CFG, 32'h01);
        chk(fo, 4'h0);
        tmr <= 5'h18;
        wt();
        chk(fo, 4'h9);
        wr(port_pins_pkg::OFS_PORT_CFG, 32'h00);
        chk(fo, 4'h8);
        ext_val <= 8'hff;
        wr(port_pins_pkg::OFS_TIMER_CTL1, 32'h20);
        chk(fo, 4'hc);
        ext_val <= 8'h7f;
        wr(port_pins_pkg::OFS_TIMER_CTL1, 32'h30);
        chk(fo, 4'h8);
        // Digital mode set before stop, then comparators power down
        wr(port_pins_pkg::OFS_MISC, 32'h02);
        chk({dig, edge_o}, 2'b11);
        stop <= 1'b1;
        wt();
        chk(pdn_o, 1'b1);
        rd(port_pins_pkg::OFS_INT_STATUS, 32'h18, 1'b0);
        conclude();
    end
endmodule : port2_port3_pin_logic_tb

// file: tb/port_pins_checker_assertions.sv
// Concurrent checks on the pin logic ports
`timescale 1ns/1ps
module port_pins_checker #(
    parameter int BIDIR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [BIDIR_W-1:0] bidir_port_lines_oe_b_o,
    input wire logic fixed_in1_i,
    input wire logic fixed_in2_i,
    input wire logic fixed_in3_i,
    input wire logic stop_i,
    input wire logic comparator_power_down_o,
    input wire logic ext_int_req_a_o,
    input wire logic ext_int_req_b_o,
    input wire logic ext_int_req_c_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // ****************************************
    // Assertions
    // ****************************************
    AST_RESET_INPUTS: assert property (
        !$past(rst_b_i) |-> &bidir_port_lines_oe_b_o) else $error("not input");
    AST_READY_SETUP: assert property (
        psel_i && !penable_i |=> pready_o) else $error("no ready");
    AST_READY_ONLY: assert property (
        pready_o |-> $past(psel_i && !penable_i)) else $error("stray ready");
    AST_ERR_READY: assert property (
        pslverr_o |-> pready_o) else $error("error without ready");
    // Direction only moves after a completed write, never on its own
    AST_DIR_HOLD: assert property (
        !$past(pwrite_i && pready_o) && !$past(pwrite_i && pready_o, 2)
        |-> $stable(bidir_port_lines_oe_b_o)) else $error("oe moved");
    AST_PWRDN_ON: assert property (
        stop_i [*2] |-> comparator_power_down_o) else $error("no power down");
    AST_PWRDN_OFF: assert property (
        !stop_i [*2] |-> !comparator_power_down_o) else $error("powered down");
    AST_REQ_A: assert property (
        $fell(fixed_in2_i) |-> ##[1:2] ext_int_req_a_o) else $error("no req a");
    AST_REQ_B: assert property (
        $fell(fixed_in3_i) |-> ##[1:2] ext_int_req_b_o) else $error("no req b");
    AST_REQ_C: assert property (
        $fell(fixed_in1_i) |-> ##[1:2] ext_int_req_c_o) else $error("no req c");
    AST_REQ_PULSE: assert property (
        ext_int_req_a_o || ext_int_req_b_o || ext_int_req_c_o
        |=> !(ext_int_req_a_o || ext_int_req_b_o || ext_int_req_c_o))
        else $error("request longer than a cycle");
endmodule : port_pins_checker

bind port_pin_logic port_pins_checker #(.BIDIR_W(BIDIR_W)) u_chk (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .stop_i(stop_i),
    .bidir_port_lines_oe_b_o(bidir_port_lines_oe_b_o),
    .fixed_in1_i(fixed_in1_i), .fixed_in2_i(fixed_in2_i),
    .fixed_in3_i(fixed_in3_i),
    .comparator_power_down_o(comparator_power_down_o),
    .ext_int_req_a_o(ext_int_req_a_o), .ext_int_req_b_o(ext_int_req_b_o),
    .ext_int_req_c_o(ext_int_req_c_o));
